// >>> rtl/plebm_params.svh
`ifndef PLEBM_PARAMS_SVH
`define PLEBM_PARAMS_SVH
// ==========================================
// register byte offsets
`define PLEBM_OFF_UCFG0 16'hfff8
`define PLEBM_OFF_LOWLAT 16'h0000
`define PLEBM_OFF_HILAT 16'h0004
`define PLEBM_OFF_LOWPIN 16'h0008
`define PLEBM_OFF_HIPIN 16'h000c
`define PLEBM_OFF_CPUCMD 16'h0010
`define PLEBM_OFF_BUSCTL 16'h0014
`define PLEBM_OFF_STATUS 16'h0018
// ==========================================
// configuration byte fields
`define PLEBM_UCFG_PAGE_N 1
`define PLEBM_UCFG_LONGLAT_N 4
`define PLEBM_UCFG_WS_LO 5
`define PLEBM_UCFG_WS_HI 6
// ==========================================
// reset values
`define PLEBM_LATCH_RST 8'hff
`define PLEBM_UCFG_RST 8'hff
// ==========================================
// timing: strong pull-up two oscillator periods
`define PLEBM_BOOST_NS 100
`define PLEBM_CLK_NS 50
`define PLEBM_BOOST_CYC ((`PLEBM_BOOST_NS + `PLEBM_CLK_NS - 1) / `PLEBM_CLK_NS)
`endif

// >>> rtl/plebm_pkg.sv
package plebm_pkg;
  // read-modify-write operation codes
  typedef enum logic [3:0] {
    PLEBM_OP_NONE, PLEBM_OP_AND, PLEBM_OP_OR, PLEBM_OP_XOR, PLEBM_OP_JBSC, PLEBM_OP_COMPL,
    PLEBM_OP_INC, PLEBM_OP_DEC, PLEBM_OP_DECJNZ, PLEBM_OP_MOVC, PLEBM_OP_CLRB, PLEBM_OP_SETBIT
  } plebm_op_t;
  // axi read/write channel states
  typedef enum logic [1:0] {PLEBM_IDLE, PLEBM_RESP} plebm_ch_t;
endpackage

// >>> rtl/plebm_port_mux.sv
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`include "plebm_params.svh"
// Contract
// [RL1] low/high pins driven from latch bits
// [RL2] latch one turns pull-down driver off
// [RL3] bus cycle switches driver to addr/data
// [RL4] bus use excludes general-purpose i/o
// [RL5] low port pull-up only during bus
// [RL6] read-modify-write ops read the latch
// [RL7] bit op rewrites whole latch byte
// [RL8] reset loads ones into all latches
// [RL9] writing one restores input condition
// [RL10] low port floats when latch one idle
// [RL11] strong pull-up two periods after rise
// [RL12] keeper pull-up follows pin level
// [RL13] very weak pull-up when driver off
// [RL14] page mode chosen from config bit 1
// [RL15] address/data placement per mode
// [RL16] page mode only for external code
// [RL17] code wait states from two bits
// [RL18] extended latch pulse one or three
// [RL19] config selects strobe address ranges
// [RL20] plain reads return pin levels
module plebm_port_mux
  import plebm_pkg::*;
#(
  parameter int W = 8,
  parameter logic [15:0] STROBE_SPLIT = 16'h8000
)(
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire logic [W-1:0] UCFG_BYTE,
  input wire logic S_AWVALID,
  output logic S_AWREADY,
  input wire logic [15:0] S_AWADDR,
  input wire logic S_WVALID,
  output logic S_WREADY,
  input wire logic [31:0] S_WDATA,
  input wire logic [3:0] S_WSTRB,
  output logic S_BVALID,
  input wire logic S_BREADY,
  output logic [1:0] S_BRESP,
  input wire logic S_ARVALID,
  output logic S_ARREADY,
  input wire logic [15:0] S_ARADDR,
  output logic S_RVALID,
  input wire logic S_RREADY,
  output logic [31:0] S_RDATA,
  output logic [1:0] S_RRESP,
  input wire logic BUS_CYCLE,
  input wire logic BUS_IS_CODE,
  input wire logic BUS_EXTERNAL,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [W-1:0] BUS_WDATA,
  input wire logic BUS_DATA_PHASE,
  input wire logic [W-1:0] LOW_PIN_I,
  output logic [W-1:0] LOW_PIN_O,
  output logic [W-1:0] LOW_PIN_OE,
  output logic [W-1:0] LOW_PULLUP,
  input wire logic [W-1:0] HIGH_PIN_I,
  output logic [W-1:0] HIGH_PIN_O,
  output logic [W-1:0] HIGH_PIN_OE,
  output logic [W-1:0] HIGH_STRONG_PU,
  output logic [W-1:0] HIGH_KEEPER_PU,
  output logic [W-1:0] HIGH_WEAK_PU,
  output logic PAGE_MODE,
  output logic PAGE_APPLIES,
  output logic [1:0] CODE_WAIT_STATES,
  output logic [1:0] LATCH_PULSE_CYC,
  output logic [1:0] TOTAL_CODE_WAIT,
  output logic CODE_STROBE_EN,
  output logic DATA_STROBE_EN
);
  // ==========================================
  // pin synchronisers, three stages
  logic [W-1:0] low_s1_q, low_s2_q, low_s3_q, low_pin_q;
  logic [W-1:0] hi_s1_q, hi_s2_q, hi_s3_q, hi_pin_q;
  // pin level accepted once stages two and three agree
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      low_s1_q <= 8'h00;
      low_s2_q <= 8'h00;
      low_s3_q <= 8'h00;
      hi_s1_q <= 8'h00;
      hi_s2_q <= 8'h00;
      hi_s3_q <= 8'h00;
    end else if (CLK_EN) begin
      low_s1_q <= LOW_PIN_I;
      low_s2_q <= low_s1_q;
      low_s3_q <= low_s2_q;
      hi_s1_q <= HIGH_PIN_I;
      hi_s2_q <= hi_s1_q;
      hi_s3_q <= hi_s2_q;
    end
  end
  // per-bit agreement filter
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_filt
      always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          low_pin_q[gi] <= 1'b0;
          hi_pin_q[gi] <= 1'b0;
        end else if (CLK_EN) begin
          if (low_s2_q[gi] == low_s3_q[gi]) begin
            low_pin_q[gi] <= low_s3_q[gi];
          end
          if (hi_s2_q[gi] == hi_s3_q[gi]) begin
            hi_pin_q[gi] <= hi_s3_q[gi];
          end
        end
      end
    end
  endgenerate
  // ==========================================
  // configuration byte, caught after reset release
  logic [W-1:0] ucfg_q;
  logic ucfg_taken_q;
  // sampled once, at the first enabled edge after release
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ucfg_q <= `PLEBM_UCFG_RST;
      ucfg_taken_q <= 1'b0;
    end else if (CLK_EN && !ucfg_taken_q) begin
      ucfg_q <= UCFG_BYTE; // RL14
      ucfg_taken_q <= 1'b1;
    end
  end
  wire logic [1:0] ws_code = {ucfg_q[`PLEBM_UCFG_WS_HI], ucfg_q[`PLEBM_UCFG_WS_LO]};
  assign PAGE_MODE = ~ucfg_q[`PLEBM_UCFG_PAGE_N]; // RL14
  assign PAGE_APPLIES = PAGE_MODE & BUS_CYCLE & BUS_IS_CODE & BUS_EXTERNAL; // RL16
  assign CODE_WAIT_STATES = ~ws_code; // RL17
  assign LATCH_PULSE_CYC = ucfg_q[`PLEBM_UCFG_LONGLAT_N] ? 2'd1 : 2'd3; // RL18
  // extended latch pulse counts as one extra wait; saturate at three
  // the output is only two bits wide, so three code waits plus the long
  // latch pulse cannot be told apart from three code waits alone
  wire logic [2:0] wait_sum = {1'b0, CODE_WAIT_STATES} + {2'b00, ~ucfg_q[`PLEBM_UCFG_LONGLAT_N]};
  assign TOTAL_CODE_WAIT = (BUS_EXTERNAL && BUS_IS_CODE) ? (wait_sum[2] ? 2'd3 : wait_sum[1:0]) : 2'd0;
  // strobe range: nonpage splits code above, data below; page mode opens all
  wire logic in_upper = BUS_ADDR >= STROBE_SPLIT;
  assign CODE_STROBE_EN = BUS_CYCLE & BUS_EXTERNAL & BUS_IS_CODE & (PAGE_MODE | in_upper); // RL19
  assign DATA_STROBE_EN = BUS_CYCLE & BUS_EXTERNAL & ~BUS_IS_CODE & (PAGE_MODE | ~in_upper); // RL19
  // ==========================================
  // port latches and read-modify-write engine
  logic [W-1:0] low_lat_q, hi_lat_q, hi_lat_prev_q;
  logic [1:0] boost_cnt_q [W];
  logic cmd_flag_q;
  // write decode
  // a frozen clock enable must also hold off the handshake, or the master
  // would see ready while the write is silently lost
  // address and data are only taken together, so neither channel can run
  // ahead and leave a half-accepted write behind
  wire logic wr_fire = S_AWVALID & S_WVALID & ~S_BVALID & CLK_EN;
  wire logic hit_low = S_AWADDR == `PLEBM_OFF_LOWLAT;
  wire logic hit_hi = S_AWADDR == `PLEBM_OFF_HILAT;
  wire logic hit_cmd = S_AWADDR == `PLEBM_OFF_CPUCMD;
  wire logic wr_ok = hit_low | hit_hi | hit_cmd;
  // command word: [3:0] op, [4] port select, [7:5] bit, [8] carry, [23:16] operand
  wire plebm_op_t cmd_op = plebm_op_t'(S_WDATA[3:0]);
  wire logic cmd_hi = S_WDATA[4];
  wire logic [2:0] cmd_bit = S_WDATA[7:5];
  wire logic [W-1:0] cmd_arg = S_WDATA[23:16];
  wire logic [W-1:0] rmw_src = cmd_hi ? hi_lat_q : low_lat_q; // RL6
  wire logic [W-1:0] bit_mask = 8'h01 << cmd_bit;
  logic [W-1:0] rmw_res;
  logic rmw_flag;
  // modify step; bit ops keep the other seven bits
  always_comb begin
    rmw_res = rmw_src;
    rmw_flag = 1'b0;
    case (cmd_op)
      PLEBM_OP_AND: rmw_res = rmw_src & cmd_arg;
      PLEBM_OP_OR: rmw_res = rmw_src | cmd_arg;
      PLEBM_OP_XOR: rmw_res = rmw_src ^ cmd_arg;
      PLEBM_OP_JBSC: begin
        rmw_flag = |(rmw_src & bit_mask);
        rmw_res = rmw_src & ~bit_mask; // RL7
      end
      PLEBM_OP_COMPL: rmw_res = rmw_src ^ bit_mask; // RL7
      PLEBM_OP_INC: rmw_res = rmw_src + 8'h01;
      PLEBM_OP_DEC: rmw_res = rmw_src - 8'h01;
      PLEBM_OP_DECJNZ: begin
        rmw_res = rmw_src - 8'h01;
        rmw_flag = rmw_res != 8'h00;
      end
      PLEBM_OP_MOVC: rmw_res = S_WDATA[8] ? (rmw_src | bit_mask) : (rmw_src & ~bit_mask); // RL7
      PLEBM_OP_CLRB: rmw_res = rmw_src & ~bit_mask; // RL7
      PLEBM_OP_SETBIT: rmw_res = rmw_src | bit_mask; // RL7
      default: rmw_res = rmw_src;
    endcase
  end
  wire logic cmd_go = wr_fire & hit_cmd & S_WSTRB[0] & (cmd_op != PLEBM_OP_NONE);
  // latches: direct writes, rmw write-back; an external bus cycle leaves ff in the low latch
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      low_lat_q <= `PLEBM_LATCH_RST; // RL8
      hi_lat_q <= `PLEBM_LATCH_RST; // RL8
      hi_lat_prev_q <= `PLEBM_LATCH_RST;
      cmd_flag_q <= 1'b0;
    end else if (CLK_EN) begin
      hi_lat_prev_q <= hi_lat_q;
      if (BUS_CYCLE && BUS_EXTERNAL) begin
        low_lat_q <= 8'hff;
      end else if (wr_fire && hit_low && S_WSTRB[0]) begin
        low_lat_q <= S_WDATA[7:0]; // RL9
      end else if (cmd_go && !cmd_hi) begin
        low_lat_q <= rmw_res; // RL7
      end
      if (wr_fire && hit_hi && S_WSTRB[0]) begin
        hi_lat_q <= S_WDATA[7:0]; // RL9
      end else if (cmd_go && cmd_hi) begin
        hi_lat_q <= rmw_res; // RL7
      end
      if (cmd_go) begin
        cmd_flag_q <= rmw_flag;
      end
    end
  end
  // ==========================================
  // pin drive and pull-up control
  wire logic bus_on = BUS_CYCLE & BUS_EXTERNAL;
  wire logic data_low = BUS_DATA_PHASE & ~PAGE_MODE; // RL15
  wire logic data_hi = BUS_DATA_PHASE & PAGE_MODE; // RL15
  wire logic [W-1:0] low_bus_val = data_low ? BUS_WDATA : BUS_ADDR[7:0]; // RL15
  wire logic [W-1:0] hi_bus_val = data_hi ? BUS_WDATA : BUS_ADDR[15:8]; // RL15
  wire logic [W-1:0] low_src = bus_on ? low_bus_val : low_lat_q; // RL3 RL4
  wire logic [W-1:0] hi_src = bus_on ? hi_bus_val : hi_lat_q; // RL3 RL4
  generate
    for (gi = 0; gi < W; gi++) begin : g_pin
      // strong pull-up one-shot after a latch rise
      always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          boost_cnt_q[gi] <= 2'd0;
        end else if (CLK_EN) begin
          if (!hi_lat_prev_q[gi] && hi_lat_q[gi]) begin
            boost_cnt_q[gi] <= 2'(`PLEBM_BOOST_CYC); // RL11
          end else if (boost_cnt_q[gi] != 2'd0) begin
            boost_cnt_q[gi] <= boost_cnt_q[gi] - 2'd1;
          end
        end
      end
      // pull-down only; a one turns the driver off, or bus pull-up for ones
      assign LOW_PIN_O[gi] = bus_on & low_src[gi];
      assign LOW_PIN_OE[gi] = ~low_src[gi] | bus_on; // RL1 RL2 RL10
      assign LOW_PULLUP[gi] = bus_on & low_src[gi]; // RL5
      assign HIGH_PIN_O[gi] = 1'b0;
      assign HIGH_PIN_OE[gi] = ~hi_src[gi]; // RL1 RL2
      assign HIGH_STRONG_PU[gi] = (boost_cnt_q[gi] != 2'd0) & hi_src[gi]; // RL11
      assign HIGH_KEEPER_PU[gi] = hi_pin_q[gi] & hi_src[gi]; // RL12
      assign HIGH_WEAK_PU[gi] = hi_src[gi]; // RL13
    end
  endgenerate
  // ==========================================
  // axi4-lite handshakes: single outstanding each
  logic bvalid_q, bok_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  assign S_AWREADY = wr_fire;
  assign S_WREADY = wr_fire;
  // read accepted only while running and with no answer pending
  assign S_ARREADY = S_ARVALID & ~rvalid_q & CLK_EN;
  assign S_BVALID = bvalid_q;
  assign S_BRESP = bok_q ? 2'b00 : 2'b10;
  assign S_RVALID = rvalid_q;
  assign S_RDATA = rdata_q;
  assign S_RRESP = rresp_q;
  // read decode; plain pin reads return filtered pin levels
  wire logic [15:0] ra = S_ARADDR;
  wire logic r_cfg = ra == `PLEBM_OFF_UCFG0;
  wire logic r_ll = ra == `PLEBM_OFF_LOWLAT;
  wire logic r_hl = ra == `PLEBM_OFF_HILAT;
  wire logic r_lp = ra == `PLEBM_OFF_LOWPIN;
  wire logic r_hp = ra == `PLEBM_OFF_HIPIN;
  wire logic r_st = ra == `PLEBM_OFF_STATUS;
  wire logic [31:0] rd_val = r_cfg ? {24'h0, ucfg_q} :
    r_ll ? {24'h0, low_lat_q} : r_hl ? {24'h0, hi_lat_q} :
    r_lp ? {24'h0, low_pin_q} : r_hp ? {24'h0, hi_pin_q} : // RL20
    r_st ? {30'h0, PAGE_MODE, cmd_flag_q} : 32'h0;
  wire logic rd_ok = r_cfg | r_ll | r_hl | r_lp | r_hp | r_st;
  // response registers
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bvalid_q <= 1'b0;
      bok_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'b00;
    end else if (CLK_EN) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bok_q <= wr_ok;
      end else if (S_BREADY) begin
        bvalid_q <= 1'b0;
      end
      if (S_ARREADY) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        rresp_q <= rd_ok ? 2'b00 : 2'b10;
      end else if (S_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  // ==========================================
  // checks
  a_reset_ones: assert property (@(posedge CORE_CLK) $rose(ARST_N) |-> low_lat_q == 8'hff && hi_lat_q == 8'hff)
    else $error("latches not ones after reset"); // RL8
  a_low_float: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !bus_on |-> LOW_PULLUP == 8'h00 && LOW_PIN_OE == ~low_lat_q)
    else $error("low port not open drain when idle"); // RL5
  a_bus_drive: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    bus_on && !BUS_DATA_PHASE |-> LOW_PULLUP == BUS_ADDR[7:0] && HIGH_PIN_OE == ~BUS_ADDR[15:8])
    else $error("bus address not on ports"); // RL3
  a_hi_latch: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !bus_on |-> HIGH_PIN_OE == ~hi_lat_q && HIGH_WEAK_PU == hi_lat_q)
    else $error("high port not from latch"); // RL1
  a_boost_len: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CLK_EN && !bus_on && $rose(hi_lat_q[0]) ##1 CLK_EN [*2] |-> $past(HIGH_STRONG_PU[0]) ##1 !HIGH_STRONG_PU[0])
    else $error("strong pull-up length wrong"); // RL11
  a_setbit_only: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CLK_EN && cmd_go && cmd_hi && cmd_op == PLEBM_OP_SETBIT |=> hi_lat_q == ($past(hi_lat_q) | $past(bit_mask)))
    else $error("set bit changed other bits"); // RL7
  a_page_sel: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    ucfg_taken_q |-> PAGE_MODE == ~ucfg_q[1])
    else $error("page mode select wrong"); // RL14
  a_wait_map: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    ws_code == 2'b11 |-> CODE_WAIT_STATES == 2'd0)
    else $error("wait state decode wrong"); // RL17
  a_latch_pulse: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !ucfg_q[`PLEBM_UCFG_LONGLAT_N] |-> LATCH_PULSE_CYC == 2'd3)
    else $error("extended pulse wrong"); // RL18
  a_page_code: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    PAGE_APPLIES |-> BUS_IS_CODE && BUS_EXTERNAL)
    else $error("page mode on non-external-code"); // RL16
  // a direct high latch write lands on the next enabled edge
  a_wr_lands: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr_fire && hit_hi && S_WSTRB[0] |=> hi_lat_q == $past(S_WDATA[7:0]))
    else $error("high latch write lost"); // RL1
  // nothing moves while the clock enable is low
  a_freeze_state: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !CLK_EN |=> $stable(hi_lat_q) && $stable(low_lat_q) && $stable(boost_cnt_q[0]))
    else $error("state moved while frozen"); // RL11
  // code and data strobes never open together
  a_strobe_excl: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !(CODE_STROBE_EN && DATA_STROBE_EN))
    else $error("both strobes enabled"); // RL19
  // an external bus cycle leaves all ones in the low latch
  a_bus_low_ff: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CLK_EN && bus_on |=> low_lat_q == 8'hff)
    else $error("low latch not ones after bus"); // RL4
  // plain pin read returns the filtered pin level, not the latch
  a_pin_read: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    S_ARREADY && r_hp |=> S_RVALID && S_RDATA[7:0] == $past(hi_pin_q))
    else $error("pin read wrong"); // RL20
  // keeper stays off while the pin reads zero
  a_keeper_off: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !hi_pin_q[0] |-> !HIGH_KEEPER_PU[0])
    else $error("keeper on for low pin"); // RL12
  c_bus_cycle: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) bus_on && data_hi);
  c_rmw_compl: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) cmd_go && cmd_op == PLEBM_OP_COMPL);
  // strong pull-up held across a frozen stretch
  c_freeze: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) !CLK_EN && HIGH_STRONG_PU != 8'h00);
  c_boost: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) HIGH_STRONG_PU != 8'h00);
endmodule

// >>> sim/plebm_ext_mem.sv
`timescale 1ns/1ns
// ==========================================
// board side of both ports plus the external memory
module plebm_ext_mem (
  input wire logic [7:0] low_o,
  input wire logic [7:0] low_oe,
  input wire logic [7:0] high_o,
  input wire logic [7:0] high_oe,
  input wire logic mem_drive,
  input wire logic [7:0] mem_byte,
  output logic [7:0] low_pin,
  output logic [7:0] high_pin
);
  // ==========================================
  // wire resolution
  // low port is open drain, so board pull-ups lift every undriven pin
  assign low_pin = (low_oe & low_o) | ~low_oe;
  // memory may drive the high port; the chip pull-down always wins a fight
  assign high_pin = (high_oe & high_o) | (~high_oe & (mem_drive ? mem_byte : 8'hff));
endmodule

// >>> sim/port_latch_and_external_bus_mux_test.sv
`timescale 1ns/1ns
module port_latch_and_external_bus_mux_test;
  // ==========================================
  // stimulus and observed signals
  logic CORE_CLK = 1'h0;
  logic ARST_N = 1'h0;
  logic CLK_EN = 1'h1;
  logic [7:0] UCFG_BYTE = 8'hff;
  logic S_AWVALID = 1'h0, S_WVALID = 1'h0, S_ARVALID = 1'h0;
  logic [15:0] S_AWADDR = 16'h0, S_ARADDR = 16'h0;
  logic [15:0] BUS_ADDR = 16'h8123; // fixed bus address, high byte above the strobe split
  logic [31:0] S_WDATA = 32'h0;
  logic BUS_CYCLE = 1'h0, BUS_IS_CODE = 1'h0, BUS_EXTERNAL = 1'h0, BUS_DATA_PHASE = 1'h0;
  logic [7:0] BUS_WDATA = 8'hc3;
  logic S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID;
  logic [1:0] S_BRESP, S_RRESP, CODE_WAIT_STATES, LATCH_PULSE_CYC, TOTAL_CODE_WAIT;
  logic [31:0] S_RDATA;
  logic [7:0] LOW_PIN_O, LOW_PIN_OE, LOW_PULLUP, HIGH_PIN_O, HIGH_PIN_OE;
  logic [7:0] HIGH_STRONG_PU, HIGH_KEEPER_PU, HIGH_WEAK_PU, low_pin, high_pin;
  logic PAGE_MODE, PAGE_APPLIES, CODE_STROBE_EN, DATA_STROBE_EN;
  logic mem_drive = 1'h0; // memory drives the high port when set
  logic [7:0] mem_byte = 8'h3c;
  logic [31:0] rd; // last read data
  logic [1:0] rr; // last read response
  logic [1:0] br; // last write response
  int num_errors = 0, num_checks = 0, strong_cyc = 0;
  // rmw commands on the high port and the latch each one leaves
  logic [31:0] ops [11] = '{32'h00f00011, 32'h000c0012, 32'h00ff0013, 32'h14, 32'h55, 32'h16,
    32'h17, 32'h18, 32'hf9, 32'hba, 32'h9b};
  logic [7:0] exps [11] = '{8'h50, 8'h5c, 8'ha3, 8'ha2, 8'ha6, 8'ha7, 8'ha6, 8'ha5, 8'h25, 8'h05, 8'h15};

  // ==========================================
  // design and far side
  // write/read responses always accepted, so the ready inputs stay high
  plebm_port_mux DUT (.*, .S_WSTRB(4'hf), .S_BREADY(1'h1), .S_RREADY(1'h1),
    .LOW_PIN_I(low_pin), .HIGH_PIN_I(high_pin));
  plebm_ext_mem ext_mem_u (.low_o(LOW_PIN_O), .low_oe(LOW_PIN_OE), .high_o(HIGH_PIN_O),
    .high_oe(HIGH_PIN_OE), .mem_drive(mem_drive), .mem_byte(mem_byte), .low_pin(low_pin),
    .high_pin(high_pin));

  always #25 CORE_CLK = ~CORE_CLK;
  // count cycles with every strong pull-up on
  always @(posedge CORE_CLK) if (HIGH_STRONG_PU === 8'hff) strong_cyc++;

  // ==========================================
  // checking and closing
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================
  // register bus and bus-cycle drivers
  // address and data offered together, each released once taken
  task axi_wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge CORE_CLK);
    S_AWADDR <= a;
    S_WDATA <= d;
    S_AWVALID <= 1'h1;
    S_WVALID <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge CORE_CLK);
      if (S_AWVALID && S_AWREADY) S_AWVALID <= 1'h0;
      if (S_WVALID && S_WREADY) S_WVALID <= 1'h0;
      if (S_BVALID) break;
    end
    br = S_BRESP;
    if (n == 40) chk(1'h0, 1'h1, "write timeout");
  endtask
  task axi_rd(input logic [15:0] a);
    int n;
    @(posedge CORE_CLK);
    S_ARADDR <= a;
    S_ARVALID <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge CORE_CLK);
      if (S_ARVALID && S_ARREADY) S_ARVALID <= 1'h0;
      if (S_RVALID) break;
    end
    rd = S_RDATA;
    rr = S_RRESP;
    if (n == 40) chk(1'h0, 1'h1, "read timeout");
  endtask
  // bus controls change at an edge, outputs are judged at the falling edge
  task bus(input logic c, input logic e, input logic k, input logic p);
    @(posedge CORE_CLK);
    BUS_CYCLE <= c;
    BUS_EXTERNAL <= e;
    BUS_IS_CODE <= k;
    BUS_DATA_PHASE <= p;
    @(negedge CORE_CLK);
  endtask
  task do_reset(input logic [7:0] cfg);
    @(posedge CORE_CLK);
    ARST_N <= 1'h0;
    UCFG_BYTE <= cfg;
    repeat (6) @(posedge CORE_CLK);
    ARST_N <= 1'h1;
  endtask

  // ==========================================
  // scenarios
  // one configuration byte: mode decode, address/data placement, strobes
  task cfg_case(input logic [7:0] cfg, input logic pg, input logic [1:0] ws, input logic [1:0] pl,
    input logic [1:0] tw);
    do_reset(cfg);
    axi_rd(16'h0004);
    chk(rd, 32'hff, "high latch at reset");
    axi_rd(16'hfff8);
    chk(rd, {24'h0, cfg}, "config byte");
    chk(PAGE_MODE, pg, "page mode");
    chk(CODE_WAIT_STATES, ws, "code waits");
    chk(LATCH_PULSE_CYC, pl, "latch pulse");
    // low latch cleared first so the bus source is visible against it
    axi_wr(16'h0000, 32'h0);
    bus(1'h1, 1'h1, 1'h1, 1'h0);
    chk(low_pin, 8'h23, "low address");
    chk(high_pin, 8'h81, "high address");
    chk(LOW_PULLUP, 8'h23, "bus pull-up");
    chk(PAGE_APPLIES, pg, "page use");
    chk(TOTAL_CODE_WAIT, tw, "total code waits");
    chk(CODE_STROBE_EN, 1'h1, "code strobe");
    bus(1'h1, 1'h1, 1'h0, 1'h1);
    chk(pg ? high_pin : low_pin, 8'hc3, "data placement");
    chk(DATA_STROBE_EN, pg, "data strobe");
    bus(1'h1, 1'h0, 1'h1, 1'h0);
    chk(PAGE_APPLIES, 1'h0, "internal fetch");
    chk(TOTAL_CODE_WAIT, 2'h0, "internal waits");
    bus(1'h0, 1'h0, 1'h0, 1'h0);
    axi_rd(16'h0000);
    chk(rd, 32'hff, "low latch after bus");
  endtask
  // general i/o, pull-ups, pin reads and read-modify-write
  task gpio_case;
    int i;
    axi_wr(16'h0004, 32'h5a);
    @(negedge CORE_CLK);
    chk(HIGH_PIN_OE, 8'ha5, "high drivers");
    chk(high_pin, 8'h5a, "high pins");
    chk(HIGH_WEAK_PU, 8'h5a, "very weak pull-up");
    axi_wr(16'h0000, 32'h0f);
    @(negedge CORE_CLK);
    chk(LOW_PIN_OE, 8'hf0, "low drivers");
    chk(LOW_PULLUP, 8'h0, "low pull-up idle");
    chk(low_pin & 8'hf0, 8'h0, "low pins");
    axi_wr(16'h0004, 32'h0);
    strong_cyc = 0;
    axi_wr(16'h0004, 32'hff);
    repeat (4) @(posedge CORE_CLK);
    chk(strong_cyc, 2, "strong pull-up span");
    chk(HIGH_PIN_OE, 8'h0, "back to input");
    mem_drive <= 1'h1;
    repeat (6) @(posedge CORE_CLK);
    axi_rd(16'h000c);
    chk(rd, 32'h3c, "pin read");
    axi_rd(16'h0004);
    chk(rd, 32'hff, "latch read");
    chk(HIGH_KEEPER_PU, 8'h3c, "keeper");
    // pins held low, so any op that read the pin would go wrong
    mem_byte <= 8'h00;
    axi_wr(16'h0004, 32'h5a);
    for (i = 0; i < 11; i++) begin
      axi_wr(16'h0010, ops[i]);
      axi_rd(16'h0004);
      chk(rd, {24'h0, exps[i]}, "latch after rmw");
    end
    axi_rd(16'h0014);
    chk(rr, 2'h2, "unmapped response");
    chk(rd, 32'h0, "unmapped data");
    axi_wr(16'h0014, 32'h0);
    chk(br, 2'h2, "unmapped write response");
    axi_rd(16'h0018);
    chk(rd, 32'h2, "status page bit, flag clear");
    // clock enable low freezes the strong pull-up count
    axi_wr(16'h0004, 32'h0);
    axi_wr(16'h0004, 32'hff);
    @(posedge CORE_CLK);
    CLK_EN <= 1'h0;
    repeat (4) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk(HIGH_STRONG_PU, 8'hff, "pull-up frozen");
    @(posedge CORE_CLK);
    CLK_EN <= 1'h1;
    repeat (3) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk(HIGH_STRONG_PU, 8'h0, "pull-up ends after thaw");
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    cfg_case(8'hff, 1'h0, 2'h0, 2'h1, 2'h0);
    cfg_case(8'had, 1'h1, 2'h2, 2'h3, 2'h3);
    gpio_case();
    complete_run();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
